/* File: src/cache_maint_pkg.sv */
// Constants, field layouts and carrier types of the two-way cache controller.
// How it works
// - Search address holds bits 31:2; tag is 31:14, tag index 13:4, data index 13:2.
// - Writing one to line_go starts the line command; it reads one until done.
// - Tag value: tag in 31:14, set returned in 13:4, 3:2 reserved; data: full word.
// - Region attributes cover ten 256 MB windows picked by the top address nibble.
// - Cacheable bit one caches the region; policy bit one means write-back.
// - Page base keeps address bits 31:4; low four bits are ignored.
// - Page size keeps bits 15:4; low four bits are ignored.
// - Shared start bit 0 launches page invalidation; hardware clears it when done.
// - Writes to read-only page fields are dropped and the access ends without error.
// - Two ways of 1024 sets, 16-byte lines, 32 KB, 32-bit paths.
// - Tag entry is 18 address bits plus valid and modified, 1024 x 20 per way.
// - Data arrays 4096 x 32 per way, indexed by set 13:4 and word 3:2.
// - Address is captured, then tag and data are looked up together one cycle.
// - A read miss, or a write miss in a write-back region, stalls the processor while a whole line is fetched from memory.
// - Reset leaves the cache disabled and the arrays uncleared.
// - Set commands act on way 0, way 1 or both, whatever the enable bit.
// - The set go bit starts the command, reads busy, hardware clears it.
// - Invalidate clears valid and modified with no write-back.
// - Push writes back valid modified entries then clears modified only.
// - Clear writes back valid modified entries, then clears valid and modified.
// - Set command bits 27:24 are push1, inval1, push0, inval0; both bits mean clear.
// - Line code selects search, invalidate, push, clear; physical lookup acts on hit.
// - On completion the line status shows way, modified, valid from before the action.
package cache_maint_pkg;
   localparam int unsigned TAG_W = 18;
   localparam int unsigned SET_W = 10;
   localparam int unsigned WORD_W = 2;
   localparam int unsigned SETS = 1024;
   localparam int unsigned WORDS = 4;
   localparam int unsigned REGIONS = 10;
   localparam int unsigned NIBBLES = 16;
   localparam int unsigned APB_AW = 12;
   localparam logic [SET_W-1:0] LAST_SET = 10'h3ff;
   localparam logic [WORD_W-1:0] LAST_BEAT = 2'h3;
   // Register offsets
   localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] OFF_LINE = 12'h004;
   localparam logic [APB_AW-1:0] OFF_SRCH = 12'h008;
   localparam logic [APB_AW-1:0] OFF_VAL = 12'h00c;
   localparam logic [APB_AW-1:0] OFF_REGION = 12'h020;
   localparam logic [APB_AW-1:0] OFF_PBASE = 12'h180;
   localparam logic [APB_AW-1:0] OFF_PSIZE = 12'h184;
   localparam logic [APB_AW-1:0] OFF_CLKEN = 12'h188;
   // Field positions
   localparam int unsigned CTRL_GO = 31;
   localparam int unsigned CMD_MSB = 27;
   localparam int unsigned CMD_LSB = 24;
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned LINE_GO = 0;
   localparam int unsigned CADDR_MSB = 13;
   localparam int unsigned CADDR_LSB = 2;
   localparam int unsigned LINE_WSEL = 14;
   localparam int unsigned LINE_TDSEL = 16;
   localparam int unsigned LCR_MSB = 22;
   localparam int unsigned LCR_LSB = 20;
   localparam int unsigned PHYS_LSB = 2;
   localparam int unsigned TAG_LSB = 14;
   localparam int unsigned SET_LSB = 4;
   localparam int unsigned WORD_LSB = 2;
   localparam int unsigned PAGE_START = 0;
   localparam int unsigned PBASE_LSB = 4;
   localparam int unsigned PSIZE_MSB = 15;
   localparam int unsigned PSIZE_LSB = 4;
   localparam int unsigned CLKEN_BIT = 0;
   localparam int unsigned NIB_LSB = 28;
   // Line command field inside bits 27:24
   localparam int unsigned LC_LACC = 3;
   localparam int unsigned LC_LINE_ADDRESS_SELECT = 2;
   localparam logic [1:0] LINE_COMMAND_CODE_SEARCH = 2'h0;
   // Set command field bits
   localparam int unsigned SC_PUSH1 = 3;
   localparam int unsigned SC_INV1 = 2;
   localparam int unsigned SC_PUSH0 = 1;
   localparam int unsigned SC_INV0 = 0;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic modified;
      logic valid;
   } tag_entry_t;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [31:0] wdata;
   } cpu_req_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LOOK, ST_FILL, ST_WB, ST_BYP, ST_ACT,
      ST_SET, ST_SETN, ST_LINE, ST_LDONE, ST_PAGE
   } state_t;

   typedef struct packed {
      cpu_req_t req;
      logic done;
      logic [31:0] rdata;
      logic [SET_W-1:0] wset;
      logic wway;
      logic aw;
      logic [SET_W-1:0] aset;
      logic apush;
      logic ainv;
      state_t ret;
      logic [WORD_W-1:0] beat;
      logic rr;
      logic fill_way;
      logic [27:0] pcur;
      logic [11:0] pleft;
   } ctx_t;
endpackage : cache_maint_pkg

/* File: src/two_way_cache_maintenance.sv */
// Two-way cache controller: lookup, line fill, write-back and maintenance commands.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module two_way_cache_maintenance
   import cache_maint_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor request side
   input wire logic cpu_valid,
   input wire cpu_req_t cpu_in,
   output logic cpu_ready,
   output logic [31:0] cpu_rdata,
   // Memory master side
   output logic mem_req,
   output logic mem_write,
   output logic mem_line,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata
);
   // Arrays are never reset
   tag_entry_t tag_mem [2][SETS];
   logic [31:0] data_mem [2][SETS*WORDS];

   state_t state_ff, nxt_state;
   ctx_t ctx_ff, nxt;

   logic en_ff, go_ff, lgo_ff, pstart_ff, clk_en_ff, wsel_ff, tdsel_ff;
   logic [3:0] set_cmd_ff, line_cmd_ff;
   logic [2:0] lcr_ff;
   logic [11:0] caddr_ff, psize_ff;
   logic [29:0] phys_ff;
   logic [27:0] pbase_ff;
   logic [31:0] value_ff, prdata_ff;
   logic [1:0] region_ff [NIBBLES];

   logic [1:0] tag_we, data_we;
   logic [SET_W-1:0] tag_wset;
   tag_entry_t tag_wval;
   logic [SET_W+WORD_W-1:0] data_wadr;
   logic [31:0] data_wval;
   logic fin_set, fin_line, fin_page, lcr_ld, val_ld;
   logic [2:0] lcr_nxt;
   logic [31:0] val_nxt;

   logic [31:0] lk_addr;
   logic [SET_W-1:0] lk_set;
   logic [TAG_W-1:0] lk_tag;
   tag_entry_t t0, t1, ent, act_ent;
   logic [1:0] hit;
   logic busy, apb_wr, lw, vw, use_cache, reg_ok, cacheable, wback;
   logic [3:0] nib;
   logic [SET_W+WORD_W-1:0] wadr;

   assign busy = go_ff | lgo_ff | pstart_ff;
   assign apb_wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_ff;
   assign cpu_ready = ctx_ff.done;
   assign cpu_rdata = ctx_ff.rdata;

   // Lookup address follows the job in progress
   always_comb begin
      case (state_ff)
         ST_PAGE: lk_addr = {ctx_ff.pcur, 4'h0};
         ST_LINE: lk_addr = line_cmd_ff[LC_LINE_ADDRESS_SELECT] ? {phys_ff, 2'h0}
                                                   : {18'h0_0000, caddr_ff, 2'h0};
         default: lk_addr = ctx_ff.req.addr;
      endcase
   end
   assign lk_set = lk_addr[TAG_LSB-1:SET_LSB];
   assign lk_tag = lk_addr[31:TAG_LSB];
   assign t0 = tag_mem[0][lk_set];
   assign t1 = tag_mem[1][lk_set];
   assign hit = {t1.valid && t1.tag == lk_tag, t0.valid && t0.tag == lk_tag};
   assign wadr = {lk_set, lk_addr[SET_LSB-1:WORD_LSB]};
   assign act_ent = tag_mem[ctx_ff.aw][ctx_ff.aset];

   // Region attributes of the current processor access
   assign nib = ctx_ff.req.addr[31:NIB_LSB];
   assign reg_ok = 32'(nib) < REGIONS;
   assign use_cache = en_ff & clk_en_ff;
   assign cacheable = use_cache & reg_ok & region_ff[nib][0];
   assign wback = region_ff[nib][1];

   // Way chosen by a line command, and its entry before any action
   assign lw = line_cmd_ff[LC_LINE_ADDRESS_SELECT] ? hit[1] : wsel_ff;
   assign ent = lw ? t1 : t0;
   assign vw = !t0.valid ? 1'b0 : (!t1.valid ? 1'b1 : ctx_ff.rr);

   always_comb begin
      nxt_state = state_ff;
      nxt = ctx_ff;
      nxt.done = 1'b0;
      tag_we = 2'h0;
      tag_wset = ctx_ff.aset;
      tag_wval = '0;
      data_we = 2'h0;
      data_wadr = wadr;
      data_wval = ctx_ff.req.wdata;
      fin_set = 1'b0;
      fin_line = 1'b0;
      fin_page = 1'b0;
      lcr_ld = 1'b0;
      lcr_nxt = 3'h0;
      val_ld = 1'b0;
      val_nxt = 32'h0000_0000;
      mem_req = 1'b0;
      mem_write = 1'b0;
      mem_line = 1'b0;
      mem_addr = 32'h0000_0000;
      mem_wdata = 32'h0000_0000;
      case (state_ff)
         ST_IDLE: begin
            // Maintenance wins over the processor
            if (go_ff) begin
               nxt.wset = '0;
               nxt.wway = 1'b0;
               nxt_state = ST_SET;
            end else if (lgo_ff) begin
               nxt_state = ST_LINE;
            end else if (pstart_ff) begin
               nxt.pcur = pbase_ff;
               nxt.pleft = psize_ff;
               nxt_state = ST_PAGE;
            end else if (cpu_valid && !ctx_ff.done) begin
               nxt.req = cpu_in;
               nxt_state = ST_LOOK;
            end
         end
         ST_LOOK: begin
            // Tag and data looked up together in one cycle
            if (!cacheable) begin
               nxt_state = ST_BYP;
            end else if (hit != 2'h0) begin
               if (ctx_ff.req.write) begin
                  data_we[hit[1]] = 1'b1;
                  if (wback) begin
                     tag_we[hit[1]] = 1'b1;
                     tag_wset = lk_set;
                     tag_wval = '{tag: lk_tag, modified: 1'b1, valid: 1'b1};
                     nxt.done = 1'b1;
                     nxt_state = ST_IDLE;
                  end else begin
                     nxt_state = ST_BYP;
                  end
               end else begin
                  nxt.rdata = data_mem[hit[1]][wadr];
                  nxt.done = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end else if (ctx_ff.req.write && !wback) begin
               nxt_state = ST_BYP;
            end else begin
               nxt.rr = ~ctx_ff.rr;
               nxt.fill_way = vw;
               nxt.aw = vw;
               nxt.aset = lk_set;
               nxt.beat = '0;
               nxt.apush = 1'b1;
               nxt.ainv = 1'b0;
               nxt.ret = ST_FILL;
               nxt_state = (vw ? t1.valid && t1.modified : t0.valid && t0.modified)
                           ? ST_WB : ST_FILL;
            end
         end
         ST_FILL: begin
            // Processor stays stalled while the line arrives
            mem_req = 1'b1;
            mem_line = 1'b1;
            mem_addr = {ctx_ff.req.addr[31:SET_LSB], ctx_ff.beat, 2'h0};
            if (mem_ready) begin
               data_we[ctx_ff.fill_way] = 1'b1;
               data_wadr = {lk_set, ctx_ff.beat};
               data_wval = mem_rdata;
               nxt.beat = ctx_ff.beat + 2'h1;
               if (ctx_ff.beat == LAST_BEAT) begin
                  tag_we[ctx_ff.fill_way] = 1'b1;
                  tag_wset = lk_set;
                  tag_wval = '{tag: lk_tag, modified: 1'b0, valid: 1'b1};
                  nxt_state = ST_LOOK;
               end
            end
         end
         ST_WB: begin
            mem_req = 1'b1;
            mem_write = 1'b1;
            mem_line = 1'b1;
            mem_addr = {act_ent.tag, ctx_ff.aset, ctx_ff.beat, 2'h0};
            mem_wdata = data_mem[ctx_ff.aw][{ctx_ff.aset, ctx_ff.beat}];
            if (mem_ready) begin
               nxt.beat = ctx_ff.beat + 2'h1;
               if (ctx_ff.beat == LAST_BEAT) begin
                  tag_we[ctx_ff.aw] = 1'b1;
                  tag_wval = act_ent;
                  tag_wval.modified = 1'b0;
                  tag_wval.valid = act_ent.valid & ~ctx_ff.ainv;
                  nxt_state = ctx_ff.ret;
               end
            end
         end
         ST_BYP: begin
            mem_req = 1'b1;
            mem_write = ctx_ff.req.write;
            mem_addr = ctx_ff.req.addr;
            mem_wdata = ctx_ff.req.wdata;
            if (mem_ready) begin
               if (!ctx_ff.req.write) begin
                  nxt.rdata = mem_rdata;
               end
               nxt.done = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_ACT: begin
            if (ctx_ff.apush && act_ent.valid && act_ent.modified) begin
               nxt.beat = '0;
               nxt_state = ST_WB;
            end else begin
               if (ctx_ff.ainv) begin
                  tag_we[ctx_ff.aw] = 1'b1;
               end
               nxt_state = ctx_ff.ret;
            end
         end
         ST_SET: begin
            // Per-way decode of the set command, enable ignored
            nxt.aw = ctx_ff.wway;
            nxt.aset = ctx_ff.wset;
            nxt.apush = ctx_ff.wway ? set_cmd_ff[SC_PUSH1] : set_cmd_ff[SC_PUSH0];
            nxt.ainv = ctx_ff.wway ? set_cmd_ff[SC_INV1] : set_cmd_ff[SC_INV0];
            nxt.ret = ST_SETN;
            nxt_state = ST_ACT;
         end
         ST_SETN: begin
            if (!ctx_ff.wway) begin
               nxt.wway = 1'b1;
               nxt_state = ST_SET;
            end else if (ctx_ff.wset == LAST_SET) begin
               fin_set = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt.wway = 1'b0;
               nxt.wset = ctx_ff.wset + 10'h001;
               nxt_state = ST_SET;
            end
         end
         ST_LINE: begin
            nxt_state = ST_IDLE;
            if (line_cmd_ff[LC_LACC] &&
                (line_cmd_ff[LC_LINE_ADDRESS_SELECT] || line_cmd_ff[1:0] != LINE_COMMAND_CODE_SEARCH)) begin
               fin_line = 1'b1;
            end else if (line_cmd_ff[LC_LINE_ADDRESS_SELECT] && hit == 2'h0) begin
               lcr_ld = 1'b1;
               fin_line = 1'b1;
            end else begin
               lcr_ld = 1'b1;
               lcr_nxt = {lw, ent.modified, ent.valid};
               if (line_cmd_ff[LC_LACC]) begin
                  if (tdsel_ff) begin
                     tag_we[lw] = 1'b1;
                     tag_wset = lk_set;
                     tag_wval = ent;
                     tag_wval.tag = value_ff[31:TAG_LSB];
                  end else begin
                     data_we[lw] = 1'b1;
                     data_wval = value_ff;
                  end
                  fin_line = 1'b1;
               end else begin
                  val_ld = 1'b1;
                  val_nxt = tdsel_ff ? {ent.tag, lk_set, 4'h0}
                                     : data_mem[lw][wadr];
                  if (line_cmd_ff[1:0] == LINE_COMMAND_CODE_SEARCH) begin
                     fin_line = 1'b1;
                  end else begin
                     nxt.aw = lw;
                     nxt.aset = lk_set;
                     nxt.apush = line_cmd_ff[1];
                     nxt.ainv = line_cmd_ff[0];
                     nxt.ret = ST_LDONE;
                     nxt_state = ST_ACT;
                  end
               end
            end
         end
         ST_LDONE: begin
            fin_line = 1'b1;
            nxt_state = ST_IDLE;
         end
         ST_PAGE: begin
            // One line of the range per cycle
            if (ctx_ff.pleft == 12'h000) begin
               fin_page = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               tag_we = hit;
               tag_wset = lk_set;
               nxt.pcur = ctx_ff.pcur + 28'h000_0001;
               nxt.pleft = ctx_ff.pleft - 12'h001;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         ctx_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         ctx_ff <= nxt;
      end
   end

   // Array write ports
   always_ff @(posedge clk_sys) begin
      for (int w = 0; w < 2; w++) begin
         if (tag_we[w]) begin
            tag_mem[w][tag_wset] <= tag_wval;
         end
         if (data_we[w]) begin
            data_mem[w][data_wadr] <= data_wval;
         end
      end
   end

   // Software-visible registers; job fields are frozen while any job runs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         en_ff <= 1'b0;
         go_ff <= 1'b0;
         set_cmd_ff <= 4'h0;
         lgo_ff <= 1'b0;
         line_cmd_ff <= 4'h0;
         wsel_ff <= 1'b0;
         tdsel_ff <= 1'b0;
         caddr_ff <= 12'h000;
         lcr_ff <= 3'h0;
         phys_ff <= 30'h0000_0000;
         value_ff <= 32'h0000_0000;
         pbase_ff <= 28'h000_0000;
         psize_ff <= 12'h000;
         pstart_ff <= 1'b0;
         clk_en_ff <= 1'b0;
         for (int i = 0; i < NIBBLES; i++) begin
            region_ff[i] <= 2'h0;
         end
      end else begin
         if (apb_wr) begin
            case (paddr)
               OFF_CTRL: begin
                  en_ff <= pwdata[CTRL_EN];
                  if (!busy) begin
                     set_cmd_ff <= pwdata[CMD_MSB:CMD_LSB];
                     go_ff <= pwdata[CTRL_GO];
                  end
               end
               OFF_LINE: if (!busy) begin
                  line_cmd_ff <= pwdata[CMD_MSB:CMD_LSB];
                  tdsel_ff <= pwdata[LINE_TDSEL];
                  wsel_ff <= pwdata[LINE_WSEL];
                  caddr_ff <= pwdata[CADDR_MSB:CADDR_LSB];
                  lgo_ff <= pwdata[LINE_GO];
               end
               OFF_SRCH: if (!busy) begin
                  phys_ff <= pwdata[31:PHYS_LSB];
                  lgo_ff <= pwdata[LINE_GO];
               end
               OFF_VAL: if (!busy) begin
                  value_ff <= pwdata;
               end
               OFF_REGION: begin
                  for (int i = 0; i < REGIONS; i++) begin
                     region_ff[i] <= pwdata[2*i +: 2];
                  end
               end
               OFF_PBASE: if (!busy) begin
                  pbase_ff <= pwdata[31:PBASE_LSB];
                  pstart_ff <= pwdata[PAGE_START];
               end
               OFF_PSIZE: if (!busy) begin
                  psize_ff <= pwdata[PSIZE_MSB:PSIZE_LSB];
                  pstart_ff <= pwdata[PAGE_START];
               end
               OFF_CLKEN: clk_en_ff <= pwdata[CLKEN_BIT];
               default: ;
            endcase
         end
         if (fin_set) begin
            go_ff <= 1'b0;
         end
         if (fin_line) begin
            lgo_ff <= 1'b0;
         end
         if (fin_page) begin
            pstart_ff <= 1'b0;
         end
         if (lcr_ld) begin
            lcr_ff <= lcr_nxt;
         end
         if (val_ld) begin
            value_ff <= val_nxt;
         end
      end
   end

   // Read data is fetched in the setup phase
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= 32'h0000_0000;
         case (paddr)
            OFF_CTRL: begin
               prdata_ff[CTRL_GO] <= go_ff;
               prdata_ff[CMD_MSB:CMD_LSB] <= set_cmd_ff;
               prdata_ff[CTRL_EN] <= en_ff;
            end
            OFF_LINE: begin
               prdata_ff[CMD_MSB:CMD_LSB] <= line_cmd_ff;
               prdata_ff[LCR_MSB:LCR_LSB] <= lcr_ff;
               prdata_ff[LINE_TDSEL] <= tdsel_ff;
               prdata_ff[LINE_WSEL] <= wsel_ff;
               prdata_ff[CADDR_MSB:CADDR_LSB] <= caddr_ff;
               prdata_ff[LINE_GO] <= lgo_ff;
            end
            OFF_SRCH: begin
               prdata_ff[31:PHYS_LSB] <= phys_ff;
               prdata_ff[LINE_GO] <= lgo_ff;
            end
            OFF_VAL: prdata_ff <= value_ff;
            OFF_REGION: begin
               for (int i = 0; i < REGIONS; i++) begin
                  prdata_ff[2*i +: 2] <= region_ff[i];
               end
            end
            OFF_PBASE: begin
               prdata_ff[31:PBASE_LSB] <= pbase_ff;
               prdata_ff[PAGE_START] <= pstart_ff;
            end
            OFF_PSIZE: begin
               prdata_ff[PSIZE_MSB:PSIZE_LSB] <= psize_ff;
               prdata_ff[PAGE_START] <= pstart_ff;
            end
            OFF_CLKEN: prdata_ff[CLKEN_BIT] <= clk_en_ff;
            default: ;
         endcase
      end
   end
endmodule : two_way_cache_maintenance
`default_nettype wire

/* File: verification/cache_maint_asserts.sv */
// Port checks for the two-way cache controller
`timescale 1ns/1ps
`default_nettype none
module cache_maint_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Processor handshake
   input wire logic cpu_valid,
   input wire logic cpu_ready,
   // Memory side
   input wire logic mem_req,
   input wire logic mem_ready,
   input wire logic mem_line,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_zero_wait: assert property (psel |-> pready)
      else $error("apb wait state");
   a_no_error: assert property (psel && penable |-> !pslverr)
      else $error("apb error");
   a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
      else $error("ready too long");
   a_ready_cause: assert property (cpu_ready |-> cpu_valid)
      else $error("ready without request");
   a_beat_hold: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
      else $error("beat dropped");
   a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
      else $error("beat not aligned");
   a_beat_step: assert property (
      mem_req && mem_ready && mem_line && mem_addr[3:2] != 2'h3
      |=> mem_req && mem_line && mem_addr == $past(mem_addr) + 32'h0000_0004)
      else $error("line beat order");
   a_line_start: assert property ($rose(mem_line) |-> mem_addr[3:2] == 2'h0)
      else $error("line start");
   a_single_cpu: assert property (mem_req && !mem_line |-> cpu_valid)
      else $error("stray single beat");
   cover property (mem_req && mem_ready && mem_line);
   cover property (mem_req && mem_ready && !mem_line);
   cover property (cpu_ready);
   cover property (mem_req && mem_ready && mem_line && mem_write);
endmodule : cache_maint_asserts
`default_nettype wire

/* File: verification/mem_partner.sv */
// Memory side model answering single and line beats
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Beat request from the cache
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   // Answer delay in cycles
   input wire logic [3:0] wait_n,
   // Beat answer
   output logic mem_ready,
   output logic [31:0] mem_rdata
);
   logic [3:0] cnt_ff;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 4'h0;
         mem_ready <= 1'b0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_req && !mem_ready && cnt_ff >= wait_n) begin
         mem_ready <= 1'b1;
         mem_rdata <= mem_addr ^ 32'ha5a5_0000;
         cnt_ff <= 4'h0;
      end else begin
         // Data not valid outside a beat
         mem_ready <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt_ff <= mem_req ? cnt_ff + 4'h1 : 4'h0;
      end
   end
endmodule : mem_partner
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the two-way cache controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h", $time, a); end end
module tb_top;
   import cache_maint_pkg::*;
   logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, cpu_valid = 0;
   logic pready, pslverr, cpu_ready, mem_req, mem_write, mem_line, mem_ready;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, q;
   logic [3:0] wait_n = 4'h0;
   logic [31:0] wb_seen = '0;
   cpu_req_t cpu_in = '0;
   int n_mismatch = 0, comparisons = 0, beats = 0;
   two_way_cache_maintenance i_two_way_cache_maintenance (.*);
   mem_partner i_mem_partner (.*);
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (mem_req && mem_ready) beats++;
      if (mem_req && mem_ready && mem_write && mem_addr == 32'h0000_0048) wb_seen = mem_wdata;
   end
   task final_report;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      q = prdata;
      `CHK(pslverr, 1'b0)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task poll(input logic [11:0] a, input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0000_0000);
         n++;
      end while (q[b] === 1'b1 && n < 3000);
      `CHK(q[b], 1'b0)
   endtask : poll
   task cpu_req(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      cpu_in <= '{addr: a, write: w, wdata: d};
      cpu_valid <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (cpu_ready !== 1'b1);
      cpu_valid <= 1'b0;
   endtask : cpu_req
   task cpu_rd(input logic [31:0] a);
      cpu_req(1'b0, a, 32'h0000_0000);
      `CHK(cpu_rdata, a ^ 32'ha5a5_0000)
   endtask : cpu_rd
   task t_regs;
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      apb(1'b1, 12'h000, 32'h8500_0000);
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK(q[31], 1'b1)
      poll(12'h000, 31);
      apb(1'b1, 12'h180, 32'h1234_5678);
      apb(1'b0, 12'h180, 32'h0000_0000);
      `CHK(q, 32'h1234_5670)
      apb(1'b1, 12'h184, 32'hffff_fffe);
      apb(1'b0, 12'h184, 32'h0000_0000);
      `CHK(q, 32'h0000_fff0)
      apb(1'b1, 12'h010, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
   endtask : t_regs
   task t_cpu;
      apb(1'b1, 12'h188, 32'h0000_0001);
      apb(1'b1, 12'h020, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0001);
      wait_n <= 4'h3;
      cpu_rd(32'h0000_0040);
      `CHK(beats, 4)
      wait_n <= 4'h0;
      cpu_rd(32'h0000_0044);
      `CHK(beats, 4)
      cpu_rd(32'ha000_0000);
      `CHK(beats, 5)
   endtask : t_cpu
   task t_maint;
      apb(1'b1, 12'h000, 32'h8a00_0001);
      poll(12'h000, 31);
      `CHK(beats, 5)
      apb(1'b1, 12'h004, 32'h0400_0000);
      apb(1'b1, 12'h008, 32'h0000_0041);
      poll(12'h004, 0);
      `CHK(q[22:20], 3'b001)
      apb(1'b0, 12'h00c, 32'h0000_0000);
      `CHK(q, 32'ha5a5_0040)
      apb(1'b1, 12'h184, 32'h0000_0010);
      apb(1'b1, 12'h180, 32'h0000_0041);
      poll(12'h180, 0);
      cpu_rd(32'h0000_0048);
      `CHK(beats, 9)
   endtask : t_maint
   task t_wback;
      apb(1'b1, 12'h020, 32'h0000_0003);
      cpu_req(1'b1, 32'h0000_0048, 32'h1357_9bdf);
      `CHK(beats, 9)
      apb(1'b1, 12'h000, 32'h8a00_0001);
      poll(12'h000, 31);
      `CHK(beats, 13)
      `CHK(wb_seen, 32'h1357_9bdf)
   endtask : t_wback
   initial begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs;
      t_cpu;
      t_maint;
      t_wback;
      final_report;
   end
   initial begin
      #800_000;
      n_mismatch++;
      final_report;
   end
endmodule : tb_top
bind two_way_cache_maintenance cache_maint_asserts i_cache_maint_asserts (.*);
`default_nettype wire
